// ---- design/codec_cfg_regs.vh ----
`ifndef CODEC_CFG_REGS_VH
`define CODEC_CFG_REGS_VH

// Register addresses within the 5-bit address field
`define ADDR_SAMPLE_PHASE_OFFSET   5'h03
`define ADDR_GAIN_SELECT           5'h04
`define ADDR_ANALOG_CONFIGURATION  5'h05
`define ADDR_DIGITAL_CONFIGURATION 5'h06
`define ADDR_DELAYED_SYNC_SPACING  5'h07
`define ADDR_SYNC_PULSE_COUNT      5'h08

// Reset values
`define RST_SAMPLE_PHASE_OFFSET    8'h00
`define RST_GAIN_SELECT            8'h05
`define RST_ANALOG_CONFIGURATION   8'h01
`define RST_DIGITAL_CONFIGURATION  8'h00
`define RST_DELAYED_SYNC_SPACING   8'h00
`define RST_SYNC_PULSE_COUNT       8'h01
`define RST_INPUT_SOURCE           2'h1

// Command word layout (bit positions in the 16-bit word)
`define CMD_WIDTH                  5'h10
`define CMD_HEADER_BITS            5'h08
`define CMD_RW_BIT                 13
`define CMD_ADDR_MSB               12
`define CMD_ADDR_LSB               8
`define CMD_DATA_MSB               7
`define CMD_DATA_LSB               0

// Gain select fields
`define GAIN_MON_MSB               5
`define GAIN_MON_LSB               4
`define GAIN_IN_MSB                3
`define GAIN_IN_LSB                2
`define GAIN_OUT_MSB               1
`define GAIN_OUT_LSB               0

// Analog configuration fields
`define ANA_NIBBLE_MSB             3
`define ANA_HPF_BYPASS_BIT         2
`define ANA_SRC_MSB                1
`define ANA_SRC_LSB                0

// Digital configuration fields
`define DIG_SOFT_RESET_BIT         1
`define DIG_POWER_DOWN_BIT         0

// Gain codes
`define GAIN_CODE_SQUELCH          2'h0
`define GAIN_CODE_UNITY            2'h1
`define GAIN_CODE_STEP1            2'h2
`define GAIN_CODE_STEP2            2'h3

// Gains in decibels, signed six bits
`define DB_ZERO                    6'h00
`define DB_MON_STEP1               6'h38
`define DB_MON_STEP2               6'h2e
`define DB_IN_STEP1                6'h06
`define DB_IN_STEP2                6'h0c
`define DB_OUT_STEP1               6'h3a
`define DB_OUT_STEP2               6'h34

`endif

// ---- design/sync_2ff.v ----
// Two-flop synchroniser for a level from outside the clock domain
module sync_2ff (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_async,
  output wire o_sync
);

  reg meta_q;  // First stage, read only by the second
  reg sync_q;  // Second stage, safe to use

  // Plain two-stage chain
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// ---- design/cfg_byte_reg.v ----
// One 8-bit configuration register with a reset value and soft clear
module cfg_byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_clear,
  input  wire       i_write,
  input  wire [7:0] i_wdata,
  output wire [7:0] o_value
);

  reg [7:0] value_q;  // Stored byte

  // Soft clear takes priority so a reset command cannot be half-applied
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      value_q <= RESET_VALUE;
    end else if (i_clear) begin
      value_q <= RESET_VALUE;
    end else if (i_write) begin
      value_q <= i_wdata;
    end
  end

  assign o_value = value_q;

endmodule

// ---- design/codec_config_registers.v ----
`include "codec_cfg_regs.vh"

// Notes on behaviour
// - Addresses 3 to 8 select the six registers
// - Phase offset is signed master-clock period count
// - Phase offset resets to zero
// - Gain fields: monitor 5..4, input 3..2, output 1..0
// - Monitor gain: squelch, 0, -8, -18 dB
// - Input gain: squelch, 0, 6, 12 dB
// - Output gain: squelch, 0, -6, -12 dB
// - Gain select resets to five
// - Analog bits 1..0 choose the input source
// - Filter bit resets zero; one bypasses filter
// - Analog low nibble resets to 0001
// - Analog read repeats low nibble in high nibble
// - Digital configuration resets to all zeros
// - Delayed sync spacing in shift clocks, at least 18; no floor is enforced, any value is stored
// - Delayed sync spacing resets to zero
// - Sync count sets frame syncs per period
// - Sync count resets to one
// - Digital bit 0 selects software power-down
// - Command takes effect on sixteenth falling shift edge
// - Read returns eight zeros then register byte
module codec_config_registers (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_shift_clk,
  input  wire       i_data_in,
  input  wire       i_frame_sync_n,
  output reg        o_data_out,
  output wire [7:0] o_sample_phase_offset,
  output wire [1:0] o_monitor_gain_code,
  output wire [1:0] o_input_gain_code,
  output wire [1:0] o_output_gain_code,
  output reg  [5:0] o_monitor_gain_db,
  output reg        o_monitor_squelch,
  output reg  [5:0] o_input_gain_db,
  output reg        o_input_squelch,
  output reg  [5:0] o_output_gain_db,
  output reg        o_output_squelch,
  output reg  [1:0] o_input_source,
  output reg        o_hpf_bypass,
  output reg        o_soft_power_down,
  output reg        o_soft_reset,
  output wire [7:0] o_delayed_sync_spacing,
  output wire [7:0] o_sync_pulse_count
);

  // Synchronised link signals
  wire       sclk_s;          // Shift clock after two flops
  wire       din_s;           // Serial data after two flops
  wire       fs_n_s;          // Frame sync after two flops

  // Edge detection history
  reg        sclk_prev_q;     // Shift clock one cycle back
  reg        fs_n_prev_q;     // Frame sync one cycle back

  // Serial receive state
  reg [15:0] rx_shift_q;      // Incoming command, first bit ends at top
  reg [4:0]  bit_cnt_q;       // Falling edges seen this frame
  reg        in_frame_q;      // A command frame is being received
  reg [7:0]  tx_shift_q;      // Outgoing read data
  reg        write_q;         // One-cycle write strobe
  reg [4:0]  wr_addr_q;       // Address for the strobe
  reg [7:0]  wr_data_q;       // Data for the strobe

  // Register file outputs
  wire [7:0] phase_val;
  wire [7:0] gain_val;
  wire [7:0] analog_val;
  wire [7:0] digital_val;
  wire [7:0] spacing_val;
  wire [7:0] count_val;

  // Decoded strobes
  wire       sclk_fall;
  wire       sclk_rise;
  wire       fs_start;
  wire [15:0] rx_next;
  wire       we_phase;
  wire       we_gain;
  wire       we_analog;
  wire       we_digital;
  wire       we_spacing;
  wire       we_count;
  reg  [7:0] read_data;

  // Every link pin passes two flops before any logic reads it
  sync_2ff u_sync_sclk (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_shift_clk),
    .o_sync    (sclk_s)
  );

  sync_2ff u_sync_din (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_data_in),
    .o_sync    (din_s)
  );

  sync_2ff u_sync_fs (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_frame_sync_n),
    .o_sync    (fs_n_s)
  );

  // Edge history, taken from synchronised copies only
  // Reset levels match the synchroniser outputs, which reset low; an idle-high
  // frame sync then rises through the chain instead of faking a start edge
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev_q <= 1'b0;
      fs_n_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      fs_n_prev_q <= fs_n_s;
    end
  end

  // Edge strobes last one cycle each
  assign sclk_fall = sclk_prev_q & ~sclk_s;
  assign sclk_rise = ~sclk_prev_q & sclk_s;
  assign fs_start  = fs_n_prev_q & ~fs_n_s;
  assign rx_next   = {rx_shift_q[14:0], din_s};

  // Read mux; unmapped addresses read zero
  // Used when the header is complete, so the address still sits in the
  // low five bits of the incoming word
  always @* begin
    case (rx_next[`CMD_ADDR_MSB - `CMD_ADDR_LSB:0])
      `ADDR_SAMPLE_PHASE_OFFSET:   read_data = phase_val;
      `ADDR_GAIN_SELECT:           read_data = gain_val;
      `ADDR_ANALOG_CONFIGURATION:  read_data = {analog_val[`ANA_NIBBLE_MSB:0],
                                                analog_val[`ANA_NIBBLE_MSB:0]};
      `ADDR_DIGITAL_CONFIGURATION: read_data = digital_val;
      `ADDR_DELAYED_SYNC_SPACING:  read_data = spacing_val;
      `ADDR_SYNC_PULSE_COUNT:      read_data = count_val;
      default:                     read_data = 8'h00;
    endcase
  end

  // Receive: sample data on each falling shift edge
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_shift_q <= 16'h0000;
      bit_cnt_q  <= 5'h00;
      in_frame_q <= 1'b0;
      write_q    <= 1'b0;
      wr_addr_q  <= 5'h00;
      wr_data_q  <= 8'h00;
      tx_shift_q <= 8'h00;
    end else begin
      // Strobe defaults low; set only on the sixteenth falling edge
      write_q <= 1'b0;
      if (fs_start) begin
        // New frame restarts the count; a short frame is simply dropped
        bit_cnt_q  <= 5'h00;
        in_frame_q <= 1'b1;
        tx_shift_q <= 8'h00;
      end else if (in_frame_q && sclk_fall) begin
        rx_shift_q <= rx_next;
        bit_cnt_q  <= bit_cnt_q + 5'h01;
        // Header complete: load the byte to return, or zeros on write
        if (bit_cnt_q + 5'h01 == `CMD_HEADER_BITS) begin
          // Write frames return zeros for the whole word
          tx_shift_q <= 8'h00;
          if (rx_next[`CMD_RW_BIT - `CMD_ADDR_LSB]) begin
            // Snapshot here so nothing later in the frame can tear the byte
            tx_shift_q <= read_data;
          end
        end
        // Sixteenth falling edge latches a write
        if (bit_cnt_q + 5'h01 == `CMD_WIDTH) begin
          in_frame_q <= 1'b0;
          // Read frames leave every register untouched
          write_q    <= ~rx_next[`CMD_RW_BIT];
          wr_addr_q  <= rx_next[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
          wr_data_q  <= rx_next[`CMD_DATA_MSB:`CMD_DATA_LSB];
        end
      end else if (in_frame_q && sclk_rise && bit_cnt_q >= `CMD_HEADER_BITS) begin
        // Rising edges after the header move the next read bit up
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
    end
  end

  // Serial out: zeros during the header, then read byte MSB first
  // Changes only on rising shift edges and frame start, so the host sees a settled bit when
  // it samples before the following falling edge
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_out <= 1'b0;
    end else if (fs_start) begin
      o_data_out <= 1'b0;
    end else if (in_frame_q && sclk_rise) begin
      o_data_out <= (bit_cnt_q >= `CMD_HEADER_BITS) ? tx_shift_q[7] : 1'b0;
    end
  end

  // Address decode into per-register write strobes
  // Unmapped addresses match no strobe and are dropped
  assign we_phase   = write_q && wr_addr_q == `ADDR_SAMPLE_PHASE_OFFSET;
  assign we_gain    = write_q && wr_addr_q == `ADDR_GAIN_SELECT;
  assign we_analog  = write_q && wr_addr_q == `ADDR_ANALOG_CONFIGURATION;
  assign we_digital = write_q && wr_addr_q == `ADDR_DIGITAL_CONFIGURATION;
  assign we_spacing = write_q && wr_addr_q == `ADDR_DELAYED_SYNC_SPACING;
  assign we_count   = write_q && wr_addr_q == `ADDR_SYNC_PULSE_COUNT;

  // Signed offset, held raw for the sampling timer
  cfg_byte_reg #(.RESET_VALUE(`RST_SAMPLE_PHASE_OFFSET)) u_phase (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_phase),
    .i_wdata   (wr_data_q),
    .o_value   (phase_val)
  );

  // Gain codes; decoded to decibels further down
  cfg_byte_reg #(.RESET_VALUE(`RST_GAIN_SELECT)) u_gain (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_gain),
    .i_wdata   (wr_data_q),
    .o_value   (gain_val)
  );

  // Reserved bits are stored as written; host keeps them zero
  cfg_byte_reg #(.RESET_VALUE(`RST_ANALOG_CONFIGURATION)) u_analog (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_analog),
    .i_wdata   (wr_data_q),
    .o_value   (analog_val)
  );

  // Soft reset bit is never stored, so it always reads back zero
  cfg_byte_reg #(.RESET_VALUE(`RST_DIGITAL_CONFIGURATION)) u_digital (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_digital),
    .i_wdata   (wr_data_q & ~(8'h01 << `DIG_SOFT_RESET_BIT)),
    .o_value   (digital_val)
  );

  // No floor enforced; values under 18 are the host's fault
  cfg_byte_reg #(.RESET_VALUE(`RST_DELAYED_SYNC_SPACING)) u_spacing (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_spacing),
    .i_wdata   (wr_data_q),
    .o_value   (spacing_val)
  );

  // Frame syncs per conversion period, slaves plus one
  cfg_byte_reg #(.RESET_VALUE(`RST_SYNC_PULSE_COUNT)) u_count (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (o_soft_reset),
    .i_write   (we_count),
    .i_wdata   (wr_data_q),
    .o_value   (count_val)
  );

  // Register values and gain fields go straight out of their flops
  assign o_sample_phase_offset  = phase_val;
  assign o_monitor_gain_code    = gain_val[`GAIN_MON_MSB:`GAIN_MON_LSB];
  assign o_input_gain_code      = gain_val[`GAIN_IN_MSB:`GAIN_IN_LSB];
  assign o_output_gain_code     = gain_val[`GAIN_OUT_MSB:`GAIN_OUT_LSB];
  assign o_delayed_sync_spacing = spacing_val;
  assign o_sync_pulse_count     = count_val;

  // Soft reset pulse: one cycle after the write, clears all six registers
  // Registered so the clear never meets the write of the same byte; the
  // bit itself is masked out of the store
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= we_digital & wr_data_q[`DIG_SOFT_RESET_BIT];
    end
  end

  // Registered control decode for the analog side
  // One cycle behind the registers, like the decibel outputs
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_input_source    <= `RST_INPUT_SOURCE;
      o_hpf_bypass      <= 1'b0;
      o_soft_power_down <= 1'b0;
    end else begin
      o_input_source    <= analog_val[`ANA_SRC_MSB:`ANA_SRC_LSB];
      o_hpf_bypass      <= analog_val[`ANA_HPF_BYPASS_BIT];
      o_soft_power_down <= digital_val[`DIG_POWER_DOWN_BIT];
    end
  end

  // Gain decode to signed decibels plus squelch flags
  // Squelch codes read 0 dB; the flag carries the mute
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_monitor_gain_db <= `DB_ZERO;
      o_monitor_squelch <= 1'b1;
      o_input_gain_db   <= `DB_ZERO;
      o_input_squelch   <= 1'b0;
      o_output_gain_db  <= `DB_ZERO;
      o_output_squelch  <= 1'b0;
    end else begin
      o_monitor_squelch <= o_monitor_gain_code == `GAIN_CODE_SQUELCH;
      o_input_squelch   <= o_input_gain_code == `GAIN_CODE_SQUELCH;
      o_output_squelch  <= o_output_gain_code == `GAIN_CODE_SQUELCH;
      // Monitor steps attenuate
      case (o_monitor_gain_code)
        `GAIN_CODE_STEP1: o_monitor_gain_db <= `DB_MON_STEP1;
        `GAIN_CODE_STEP2: o_monitor_gain_db <= `DB_MON_STEP2;
        default:          o_monitor_gain_db <= `DB_ZERO;
      endcase
      // Input steps amplify
      case (o_input_gain_code)
        `GAIN_CODE_STEP1: o_input_gain_db <= `DB_IN_STEP1;
        `GAIN_CODE_STEP2: o_input_gain_db <= `DB_IN_STEP2;
        default:          o_input_gain_db <= `DB_ZERO;
      endcase
      // Output steps attenuate
      case (o_output_gain_code)
        `GAIN_CODE_STEP1: o_output_gain_db <= `DB_OUT_STEP1;
        `GAIN_CODE_STEP2: o_output_gain_db <= `DB_OUT_STEP2;
        default:          o_output_gain_db <= `DB_ZERO;
      endcase
    end
  end

endmodule

// ---- dv/codec_cfg_checker_assertions.sv ----
// Watches the register bank from its top-level ports only
module codec_cfg_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_shift_clk,
  input wire logic [7:0] o_sample_phase_offset,
  input wire logic [1:0] o_monitor_gain_code,
  input wire logic [1:0] o_input_gain_code,
  input wire logic [1:0] o_output_gain_code,
  input wire logic [5:0] o_monitor_gain_db,
  input wire logic [5:0] o_input_gain_db,
  input wire logic [5:0] o_output_gain_db,
  input wire logic       o_monitor_squelch,
  input wire logic       o_soft_power_down,
  input wire logic       o_soft_reset,
  input wire logic [7:0] o_delayed_sync_spacing,
  input wire logic [7:0] o_sync_pulse_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Decibel tables packed code 3 down to code 0; squelch reads as 0 dB
  localparam logic [23:0] MON_DB = {6'h2e, 6'h38, 6'h00, 6'h00};
  localparam logic [23:0] IN_DB  = {6'h0c, 6'h06, 6'h00, 6'h00};
  localparam logic [23:0] OUT_DB = {6'h34, 6'h3a, 6'h00, 6'h00};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_reset_values: assert property (
    $fell(i_rst) |-> o_sample_phase_offset == 8'h00 && o_monitor_gain_code == 2'h0
      && o_input_gain_code == 2'h1 && o_output_gain_code == 2'h1 && !o_soft_power_down
      && o_delayed_sync_spacing == 8'h00 && o_sync_pulse_count == 8'h01)
    else $error("register outputs wrong after reset");
  // Decoded gains trail their code by one cycle
  a_monitor_map: assert property (
    o_monitor_gain_db == MON_DB[$past(o_monitor_gain_code) * 6 +: 6]
      && o_monitor_squelch == ($past(o_monitor_gain_code) == 2'h0))
    else $error("monitor gain decode wrong");
  a_input_map: assert property (
    o_input_gain_db == IN_DB[$past(o_input_gain_code) * 6 +: 6])
    else $error("input gain decode wrong");
  a_output_map: assert property (
    o_output_gain_db == OUT_DB[$past(o_output_gain_code) * 6 +: 6])
    else $error("output gain decode wrong");
  a_soft_pulse: assert property (
    o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse too long");
  a_soft_restore: assert property (
    o_soft_reset |-> ##[0:2] (o_sample_phase_offset == 8'h00 && o_sync_pulse_count == 8'h01
      && o_delayed_sync_spacing == 8'h00 && o_input_gain_code == 2'h1 && !o_soft_power_down))
    else $error("soft reset did not restore registers");
  // Updates land only after the last falling shift edge of a frame
  a_update_timing: assert property (
    ($changed(o_sample_phase_offset) || $changed(o_sync_pulse_count)
      || $changed(o_delayed_sync_spacing)) |-> !i_shift_clk && !$past(i_shift_clk, 3))
    else $error("register changed outside frame end");
  a_codes_timing: assert property (
    $changed(o_monitor_gain_code) |-> !i_shift_clk && !$past(i_shift_clk, 3))
    else $error("gain code changed outside frame end");

  c_soft_reset: cover property (o_soft_reset);
  c_power_down: cover property ($rose(o_soft_power_down));
  c_monitor_low: cover property (o_monitor_gain_code == 2'h3);
endmodule

// ---- dv/codec_host_model.sv ----
// Host side of the serial command link; shift clock idles low between frames
module codec_host_model (
  output logic      o_shift_clk,
  output logic      o_data_in,
  output logic      o_frame_sync_n,
  input  wire logic i_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5; // 125 ns link period, unrelated to system clock

  initial begin
    o_shift_clk = 1'b0;
    o_data_in = 1'b0;
    o_frame_sync_n = 1'b1;
  end

  // One frame, MSB first; fewer than 16 bits gives an aborted frame
  task automatic frame(input logic [15:0] word, output logic [15:0] seen, input int bits);
    seen = 16'h0000;
    o_frame_sync_n <= 1'b0;
    #(HALF);
    for (int i = 15; i > 15 - bits; i--) begin
      o_shift_clk <= 1'b1;
      o_data_in <= word[i];
      #(HALF);
      // Sample returned bit just before the falling edge, once it has settled
      seen[i] = i_data_out;
      o_shift_clk <= 1'b0;
      #(HALF);
    end
    o_frame_sync_n <= 1'b1;
    // Released line shows the inverse, never a stale value
    o_data_in <= ~o_data_in;
    #(4 * HALF);
  endtask
endmodule

// ---- dv/codec_config_registers_3_to_8_bench.sv ----
`define check_eq(nm, e, a) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, a); \
  end \
end

module codec_config_registers_3_to_8_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_ref_clk;
  logic       i_rst;
  wire        i_shift_clk, i_data_in, i_frame_sync_n, o_data_out;
  wire  [7:0] o_sample_phase_offset, o_delayed_sync_spacing, o_sync_pulse_count;
  wire  [1:0] o_monitor_gain_code, o_input_gain_code, o_output_gain_code, o_input_source;
  wire  [5:0] o_monitor_gain_db, o_input_gain_db, o_output_gain_db;
  wire        o_monitor_squelch, o_input_squelch, o_output_squelch;
  wire        o_hpf_bypass, o_soft_power_down, o_soft_reset;
  int         fail_count = 0;
  int         comparisons = 0;
  // Expected signed decibel codes, indexed by gain code
  localparam logic [5:0] MON_DB [4] = '{6'h00, 6'h00, 6'h38, 6'h2e};
  localparam logic [5:0] IN_DB  [4] = '{6'h00, 6'h00, 6'h06, 6'h0c};
  localparam logic [5:0] OUT_DB [4] = '{6'h00, 6'h00, 6'h3a, 6'h34};

  codec_config_registers dut_u (.*);
  codec_host_model host_u (.o_shift_clk(i_shift_clk), .o_data_in(i_data_in),
    .o_frame_sync_n(i_frame_sync_n), .i_data_out(o_data_out));

  // Write frame; control bits left zero
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.frame({3'b000, a, d}, r, 16);
  endtask

  // Read frame; whole returned word must be zeros then the byte
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    logic [15:0] r;
    host_u.frame({3'b001, a, 8'h00}, r, 16);
    `check_eq(nm, {8'h00, e}, r)
  endtask

  task automatic t_defaults();
    rd(5'h03, 8'h00, "phase");
    rd(5'h04, 8'h05, "gain");
    rd(5'h05, 8'h11, "analog");
    rd(5'h06, 8'h00, "digital");
    rd(5'h07, 8'h00, "spacing");
    rd(5'h08, 8'h01, "count");
    `check_eq("source", 2'h1, o_input_source)
    `check_eq("bypass", 1'b0, o_hpf_bypass)
  endtask

  task automatic t_write_back();
    wr(5'h03, 8'hf6); // minus ten master clocks
    `check_eq("phase out", 8'hf6, o_sample_phase_offset)
    rd(5'h03, 8'hf6, "phase back");
    wr(5'h08, 8'h03); // two slaves plus the master
    `check_eq("count out", 8'h03, o_sync_pulse_count)
    wr(5'h06, 8'h01);
    `check_eq("power down", 1'b1, o_soft_power_down)
    rd(5'h06, 8'h01, "digital back");
    wr(5'h09, 8'hff); // Unmapped address
    rd(5'h09, 8'h00, "unmapped");
    rd(5'h08, 8'h03, "count kept");
    wr(5'h07, 8'd18); // Smallest legal spacing, written last
    `check_eq("spacing out", 8'd18, o_delayed_sync_spacing)
  endtask

  // Frame cut short one bit early must not write
  task automatic t_partial();
    logic [15:0] r;
    host_u.frame({3'b000, 5'h03, 8'h55}, r, 15);
    `check_eq("partial frame", 8'hf6, o_sample_phase_offset)
    rd(5'h03, 8'hf6, "after abort");
  endtask

  task automatic t_analog();
    wr(5'h05, 8'h06); // Reserved upper bits kept zero
    `check_eq("source aux", 2'h2, o_input_source)
    `check_eq("bypass set", 1'b1, o_hpf_bypass)
    rd(5'h05, 8'h66, "analog mirror");
    for (int k = 0; k < 4; k++) begin
      wr(5'h05, 8'(k));
      `check_eq("source sel", 2'(k), o_input_source)
    end
  endtask

  // Every code in every field, fields kept distinct
  task automatic t_gains();
    logic [1:0] m, n, o;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      n = 2'(k + 1);
      o = 2'(k + 2);
      wr(5'h04, {2'b00, m, n, o});
      `check_eq("mon code", m, o_monitor_gain_code)
      `check_eq("in code", n, o_input_gain_code)
      `check_eq("out code", o, o_output_gain_code)
      `check_eq("mon db", MON_DB[m], o_monitor_gain_db)
      `check_eq("mon squelch", m == 2'h0, o_monitor_squelch)
      `check_eq("in db", IN_DB[n], o_input_gain_db)
      `check_eq("in squelch", n == 2'h0, o_input_squelch)
      `check_eq("out db", OUT_DB[o], o_output_gain_db)
      `check_eq("out squelch", o == 2'h0, o_output_squelch)
    end
  endtask

  task automatic t_soft_reset();
    wr(5'h06, 8'h02);
    rd(5'h06, 8'h00, "soft bit");
    `check_eq("phase cleared", 8'h00, o_sample_phase_offset)
    `check_eq("count cleared", 8'h01, o_sync_pulse_count)
    `check_eq("spacing cleared", 8'h00, o_delayed_sync_spacing)
    `check_eq("source cleared", 2'h1, o_input_source)
    `check_eq("mon cleared", 2'h0, o_monitor_gain_code)
    `check_eq("in cleared", 2'h1, o_input_gain_code)
    `check_eq("power cleared", 1'b0, o_soft_power_down)
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Main sequence after a two-cycle reset
  initial begin
    i_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    t_defaults();
    t_write_back();
    t_partial();
    t_analog();
    t_gains();
    t_soft_reset();
    give_verdict();
  end

  // Hang guard, far beyond the normal run
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule

bind codec_config_registers codec_cfg_checker chk_u (.*);
